/* hw/xbm_frame_if.sv */
// frame fields between serial link and register core
// assumes both ends on the same clock
`timescale 1ns/10ps
interface xbm_frame_if;
    logic        commit;
    logic        cs_fall;
    logic [1:0]  opcode;
    logic [5:0]  addr;
    logic [15:0] data;
    logic [15:0] rd_data;
    logic        mute;
    modport link (output commit, cs_fall, opcode, addr, data, input rd_data, mute);
    modport core (input commit, cs_fall, opcode, addr, data, output rd_data, mute);
endinterface

/* hw/xbm_pkg.sv */
// constants, types and helpers for the external bridge vds monitor
// assumes a 40 MHz clock and a 24-bit serial frame
package xbm_pkg;
    localparam int          CLK_PERIOD_PS  = 25000;
    localparam int          VDS_FILTER_NS  = 1000;
    localparam int          BLANK_STEP_NS  = 1000;
    localparam int          FILTER_CYC     = (VDS_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          BLANK_STEP_CYC = (BLANK_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          FRAME_BITS     = 24;
    localparam logic [5:0]  ADDR_XBM       = 6'h06;
    localparam logic [5:0]  ADDR_DIAG      = 6'h07;
    localparam logic [1:0]  OP_WRITE       = 2'h0;
    localparam logic [15:0] XBM_RESET      = 16'h0176;
    localparam int          SINK_BIT       = 15;
    localparam int          SRC_BIT        = 14;
    localparam int          ARM_BIT        = 13;
    localparam int          BLANK2_LSB     = 11;
    localparam int          BLANK1_LSB     = 9;
    localparam int          THR2_LSB       = 5;
    localparam int          THR1_LSB       = 1;
    localparam int          THR_ON_BIT     = 3;
    localparam logic        PARITY_ODD     = 1'b1;

    typedef enum logic [1:0] {
        GD_IDLE  = 2'h0,
        GD_BLANK = 2'h1,
        GD_WATCH = 2'h3,
        GD_TRIP  = 2'h2
    } xbm_guard_e;

    // parity bit that makes a frame good
    function automatic logic par_bit(input logic [22:0] x);
        return (^x) ^ PARITY_ODD;
    endfunction
endpackage

/* hw/xbm_spi_link.sv */
// serial slave: 24-bit frames, msb first, sample on sck rise
// assumes pins asynchronous to clk; sck well below clk/4
`timescale 1ns/10ps
module xbm_spi_link (
    input  wire logic  clk,           // system clock
    input  wire logic  nrst,          // async reset, low
    input  wire logic  chip_select_n, // frame select pin
    input  wire logic  sck,           // serial clock pin
    input  wire logic  mosi,          // serial data in pin
    output logic       miso_o,        // serial data out
    output logic       miso_oe_n,     // low while driving
    xbm_frame_if.link  fr             // frame to core
);
    logic [2:0]  cs_p;
    logic [2:0]  sck_p;
    logic [1:0]  mosi_p;
    logic [4:0]  cnt_q;
    logic [23:0] rx_q;
    logic [23:0] tx_q;
    logic        cs_fall;
    logic        cs_rise;
    logic        sck_rise;
    logic        sck_fall;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cs_p   <= 3'h7;
            sck_p  <= 3'h0;
            mosi_p <= 2'h0;
        end else begin
            cs_p   <= {cs_p[1:0], chip_select_n};
            sck_p  <= {sck_p[1:0], sck};
            mosi_p <= {mosi_p[0], mosi};
        end
    end

    assign cs_fall  = cs_p[2] & ~cs_p[1];
    assign cs_rise  = ~cs_p[2] & cs_p[1];
    assign sck_rise = ~sck_p[2] & sck_p[1] & ~cs_p[1];
    assign sck_fall = sck_p[2] & ~sck_p[1] & ~cs_p[1];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 5'h00;
            rx_q  <= 24'h00_0000;
        end else if (cs_fall) begin
            cnt_q <= 5'h00;
        end else if (sck_rise) begin
            rx_q  <= {rx_q[22:0], mosi_p[1]};
            cnt_q <= (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_q      <= 24'h00_0000;
            miso_o    <= 1'b0;
            miso_oe_n <= 1'b1;
        end else begin
            miso_oe_n <= cs_p[1] | fr.mute;
            if (cs_fall) begin
                tx_q   <= {OP_WRITE_HDR(), fr.rd_data[15:1],
                           xbm_pkg::par_bit({OP_WRITE_HDR(), fr.rd_data[15:1]})};
                miso_o <= 1'b0;
            end else if (sck_fall) begin
                miso_o <= tx_q[23];
                tx_q   <= {tx_q[22:0], 1'b0};
            end
        end
    end

    function automatic logic [7:0] OP_WRITE_HDR();
        return {xbm_pkg::OP_WRITE, xbm_pkg::ADDR_XBM};
    endfunction

    // full frame with good parity only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fr.commit  <= 1'b0;
            fr.cs_fall <= 1'b0;
        end else begin
            fr.commit  <= cs_rise && (cnt_q == 5'(xbm_pkg::FRAME_BITS))
                          && (xbm_pkg::par_bit(rx_q[23:1]) == rx_q[0]);
            fr.cs_fall <= cs_fall;
        end
    end

    assign fr.opcode = rx_q[23:22];
    assign fr.addr   = rx_q[21:16];
    assign fr.data   = rx_q[15:0];
endmodule

/* hw/xbm_top.sv */
// external bridge vds monitor register, standby arming, regulation select
// assumes analog comparators outside, host as serial master
`timescale 1ns/10ps
module xbm_top (
    input  wire logic        clk,                     // 40 MHz clock
    input  wire logic        nrst,                    // async reset, low
    input  wire logic        chip_select_n,           // serial select pin
    input  wire logic        sck,                     // serial clock pin
    input  wire logic        mosi,                    // serial data in
    output logic             miso_o,                  // serial data out
    output logic             miso_oe_n,               // low while driving
    input  wire logic [5:0]  regulation_type_select,  // per internal output
    input  wire logic [23:0] output_level_code,       // 4 bits per output
    output logic      [5:0]  current_reg_en,          // current loop on
    output logic      [5:0]  duty_reg_en,             // fixed duty on
    output logic      [23:0] level_code,              // level to regulator
    input  wire logic [1:0]  xbridge_on_cmd,          // bridge turn on
    input  wire logic [1:0]  vds_over,                // comparator pins
    input  wire logic [1:0]  fault_clear,             // clear fault pulse
    output logic      [1:0]  xbridge_drive,           // gate drive enable
    output logic      [1:0]  xbridge_fault,           // sticky fault
    output logic      [7:0]  xbridge_vds_threshold,   // thresholds b2,b1
    output logic             xbridge2_diag_sink_en,   // sink current
    output logic             xbridge2_diag_source_en, // source current
    output logic             standby                  // standby state
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [15:1] reg_q;
    logic        second_q;
    logic        standby_q;
    logic [1:0]  vds_p0_q;
    logic [1:0]  vds_s_q;
    logic [1:0]  trip;
    logic [1:0]  drive_q;
    logic [1:0]  fault_q;
    logic [1:0]  mon_en;
    logic [7:0]  thr_q;
    logic        sink_q;
    logic        src_q;
    logic [5:0]  cur_en_q;
    logic [5:0]  duty_en_q;
    logic [23:0] level_q;
    logic        wr_xbm;
    logic        wr_diag;

    xbm_frame_if fr ();

    // ------------------------------------------------------------
    // serial link
    // ------------------------------------------------------------
    xbm_spi_link u_link (
        .clk           (clk),
        .nrst          (nrst),
        .chip_select_n (chip_select_n),
        .sck           (sck),
        .mosi          (mosi),
        .miso_o        (miso_o),
        .miso_oe_n     (miso_oe_n),
        .fr            (fr.link)
    );

    assign fr.rd_data = {reg_q, 1'b0};
    assign fr.mute    = standby_q;

    // frames count only when awake
    assign wr_xbm  = fr.commit && !standby_q && fr.opcode == xbm_pkg::OP_WRITE
                     && fr.addr == xbm_pkg::ADDR_XBM;
    assign wr_diag = fr.commit && !standby_q && fr.opcode == xbm_pkg::OP_WRITE
                     && fr.addr == xbm_pkg::ADDR_DIAG;

    // ------------------------------------------------------------
    // monitor register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_q <= xbm_pkg::XBM_RESET[15:1];
        end else if (wr_xbm) begin
            reg_q <= fr.data[15:1];
        end else if (wr_diag && fr.data[xbm_pkg::ARM_BIT] && !second_q
                     && reg_q[xbm_pkg::ARM_BIT]) begin
            reg_q[xbm_pkg::ARM_BIT] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // standby arming
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            second_q <= 1'b0;
        end else if (wr_diag) begin
            if (fr.data[xbm_pkg::ARM_BIT] && !second_q && reg_q[xbm_pkg::ARM_BIT]) begin
                second_q <= 1'b0;
            end else begin
                second_q <= fr.data[xbm_pkg::ARM_BIT];
            end
        end
    end

    // second bit rising with first already set
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            standby_q <= 1'b0;
        end else if (standby_q) begin
            if (fr.cs_fall) begin
                standby_q <= 1'b0;
            end
        end else if (wr_diag && fr.data[xbm_pkg::ARM_BIT] && !second_q
                     && reg_q[xbm_pkg::ARM_BIT]) begin
            standby_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // diagnostic currents
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sink_q <= 1'b0;
            src_q  <= 1'b0;
        end else begin
            // both asked means neither
            sink_q <= reg_q[xbm_pkg::SINK_BIT] & ~reg_q[xbm_pkg::SRC_BIT];
            src_q  <= reg_q[xbm_pkg::SRC_BIT] & ~reg_q[xbm_pkg::SINK_BIT];
        end
    end

    // ------------------------------------------------------------
    // thresholds to comparators
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            thr_q <= {xbm_pkg::XBM_RESET[xbm_pkg::THR2_LSB +: 4], xbm_pkg::XBM_RESET[xbm_pkg::THR1_LSB +: 4]};
        end else begin
            thr_q <= {reg_q[xbm_pkg::THR2_LSB +: 4], reg_q[xbm_pkg::THR1_LSB +: 4]};
        end
    end

    // undefined codes have top bit clear, so stay off
    function automatic logic thr_on(input logic [3:0] code);
        return code[xbm_pkg::THR_ON_BIT];
    endfunction

    assign mon_en[0] = thr_on(reg_q[xbm_pkg::THR1_LSB +: 4]);
    assign mon_en[1] = thr_on(reg_q[xbm_pkg::THR2_LSB +: 4]);

    // ------------------------------------------------------------
    // comparator synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vds_p0_q <= 2'h0;
            vds_s_q  <= 2'h0;
        end else begin
            vds_p0_q <= vds_over;
            vds_s_q  <= vds_p0_q;
        end
    end

    // ------------------------------------------------------------
    // per bridge guard, drive and fault
    // ------------------------------------------------------------
    xbm_vds_guard u_guard1 (
        .clk        (clk),
        .nrst       (nrst),
        .on_cmd     (xbridge_on_cmd[0]),
        .over       (vds_s_q[0]),
        .mon_en     (mon_en[0]),
        .blank_code (reg_q[xbm_pkg::BLANK1_LSB +: 2]),
        .trip       (trip[0])
    );

    xbm_vds_guard u_guard2 (
        .clk        (clk),
        .nrst       (nrst),
        .on_cmd     (xbridge_on_cmd[1]),
        .over       (vds_s_q[1]),
        .mon_en     (mon_en[1]),
        .blank_code (reg_q[xbm_pkg::BLANK2_LSB +: 2]),
        .trip       (trip[1])
    );

    // set wins over clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fault_q <= 2'h0;
        end else begin
            fault_q <= trip | (fault_q & ~fault_clear);
        end
    end

    // steady gate enable, no duty pattern
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            drive_q <= 2'h0;
        end else begin
            drive_q <= xbridge_on_cmd & ~fault_q & ~trip & ~{2{standby_q}};
        end
    end

    // ------------------------------------------------------------
    // internal output regulation type
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_en_q  <= 6'h00;
            duty_en_q <= 6'h00;
            level_q   <= 24'h00_0000;
        end else begin
            cur_en_q  <= ~regulation_type_select & ~{6{standby_q}};
            duty_en_q <= regulation_type_select & ~{6{standby_q}};
            level_q   <= output_level_code;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign current_reg_en          = cur_en_q;
    assign duty_reg_en             = duty_en_q;
    assign level_code              = level_q;
    assign xbridge_drive           = drive_q;
    assign xbridge_fault           = fault_q;
    assign xbridge_vds_threshold   = thr_q;
    assign xbridge2_diag_sink_en   = sink_q;
    assign xbridge2_diag_source_en = src_q;
    assign standby                 = standby_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_write_lands;
        @(posedge clk) disable iff (!nrst)
        wr_xbm |=> reg_q == $past(fr.data[15:1]) ##1 thr_q[3:0] == reg_q[4:1];
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("monitor write lost");

    property p_other_addr;
        @(posedge clk) disable iff (!nrst)
        fr.commit && fr.addr != xbm_pkg::ADDR_XBM && fr.addr != xbm_pkg::ADDR_DIAG |=> $stable(reg_q);
    endproperty
    a_other_addr: assert property (p_other_addr) else $error("foreign frame changed register");

    property p_stby_enter;
        @(posedge clk) disable iff (!nrst)
        wr_diag && fr.data[xbm_pkg::ARM_BIT] && reg_q[xbm_pkg::ARM_BIT] && !second_q |=> standby_q;
    endproperty
    a_stby_enter: assert property (p_stby_enter) else $error("standby not entered");

    property p_stby_order;
        @(posedge clk) disable iff (!nrst)
        $rose(standby_q) |-> $past(reg_q[xbm_pkg::ARM_BIT]) && $past(wr_diag) && !$past(second_q);
    endproperty
    a_stby_order: assert property (p_stby_order) else $error("standby out of order");

    property p_wake;
        @(posedge clk) disable iff (!nrst)
        standby_q && fr.cs_fall |=> !standby_q ##1 !standby_q;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on select fall");

    property p_deaf;
        @(posedge clk) disable iff (!nrst)
        standby_q && fr.commit |=> $stable(reg_q) && $stable(second_q);
    endproperty
    a_deaf: assert property (p_deaf) else $error("frame taken in standby");

    property p_diag_excl;
        @(posedge clk) disable iff (!nrst)
        !(sink_q && src_q);
    endproperty
    a_diag_excl: assert property (p_diag_excl) else $error("sink and source together");

    property p_diag_map;
        @(posedge clk) disable iff (!nrst)
        wr_xbm && fr.data[xbm_pkg::SINK_BIT] && !fr.data[xbm_pkg::SRC_BIT] |=> ##1 sink_q && !src_q;
    endproperty
    a_diag_map: assert property (p_diag_map) else $error("sink enable not applied");

    property p_reg_type;
        @(posedge clk) disable iff (!nrst)
        !standby_q |=> (cur_en_q ^ duty_en_q) == 6'h3f && duty_en_q == $past(regulation_type_select);
    endproperty
    a_reg_type: assert property (p_reg_type) else $error("regulation type wrong");

    property p_fault_drop;
        @(posedge clk) disable iff (!nrst)
        |trip |=> (fault_q & $past(trip)) == $past(trip) && (drive_q & $past(trip)) == 2'h0;
    endproperty
    a_fault_drop: assert property (p_fault_drop) else $error("fault did not disable bridge");

    property p_off_no_fault;
        @(posedge clk) disable iff (!nrst)
        !mon_en[0] && !fault_q[0] |=> !fault_q[0];
    endproperty
    a_off_no_fault: assert property (p_off_no_fault) else $error("fault with monitoring off");

    property p_thr_follow;
        @(posedge clk) disable iff (!nrst)
        wr_xbm |=> ##1 thr_q == $past(fr.data[xbm_pkg::THR2_LSB + 3:xbm_pkg::THR1_LSB], 2);
    endproperty
    a_thr_follow: assert property (p_thr_follow) else $error("threshold pins not updated");

    property p_diag_src;
        @(posedge clk) disable iff (!nrst)
        wr_xbm && fr.data[xbm_pkg::SRC_BIT] && !fr.data[xbm_pkg::SINK_BIT] |=> ##1 src_q && !sink_q;
    endproperty
    a_diag_src: assert property (p_diag_src) else $error("source enable not applied");

    property p_diag_both;
        @(posedge clk) disable iff (!nrst)
        wr_xbm && fr.data[xbm_pkg::SRC_BIT] && fr.data[xbm_pkg::SINK_BIT] |=> ##1 !src_q && !sink_q;
    endproperty
    a_diag_both: assert property (p_diag_both) else $error("both diagnostic currents on");

    property p_drive_steady;
        @(posedge clk) disable iff (!nrst)
        xbridge_on_cmd == 2'h3 && fault_q == 2'h0 && trip == 2'h0 && !standby_q |=> drive_q == 2'h3;
    endproperty
    a_drive_steady: assert property (p_drive_steady) else $error("bridge drive not steady");

    property p_stby_quiet;
        @(posedge clk) disable iff (!nrst)
        standby_q |=> drive_q == 2'h0 && cur_en_q == 6'h00 && duty_en_q == 6'h00 && miso_oe_n;
    endproperty
    a_stby_quiet: assert property (p_stby_quiet) else $error("outputs active in standby");

    property p_arm_clear;
        @(posedge clk) disable iff (!nrst)
        $rose(standby_q) |-> !reg_q[xbm_pkg::ARM_BIT] && !second_q;
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("arm bits kept after entry");

    property p_fault_hold;
        @(posedge clk) disable iff (!nrst)
        fault_q[1] && !fault_clear[1] |=> fault_q[1];
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault dropped without clear");

    property p_level_copy;
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> level_q == $past(output_level_code);
    endproperty
    a_level_copy: assert property (p_level_copy) else $error("level code not passed");
endmodule

/* hw/xbm_vds_guard.sv */
// one bridge: turn on blanking then vds filter, trip pulse out
// assumes over already synchronised to clk
`timescale 1ns/10ps
module xbm_vds_guard #(
    parameter int CNT_W = 8                 // counter width
) (
    input  wire logic       clk,            // system clock
    input  wire logic       nrst,           // async reset, low
    input  wire logic       on_cmd,         // bridge commanded on
    input  wire logic       over,           // vds above threshold
    input  wire logic       mon_en,         // monitoring on
    input  wire logic [1:0] blank_code,     // blanking setting
    output logic            trip            // fault pulse
);
    localparam int MAX_CYC = 4 * xbm_pkg::BLANK_STEP_CYC;
    if ((1 << CNT_W) <= MAX_CYC) begin : g_chk
        $error("guard counter too narrow");
    end

    xbm_pkg::xbm_guard_e state_q;
    logic [CNT_W-1:0]    cnt_q;
    logic                on_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= xbm_pkg::GD_IDLE;
            cnt_q   <= '0;
            on_q    <= 1'b0;
            trip    <= 1'b0;
        end else begin
            on_q <= on_cmd;
            trip <= 1'b0;
            case (state_q)
                xbm_pkg::GD_IDLE: begin
                    if (on_cmd && !on_q) begin
                        state_q <= xbm_pkg::GD_BLANK;
                        cnt_q   <= CNT_W'((int'(blank_code) + 1) * xbm_pkg::BLANK_STEP_CYC);
                    end
                end
                xbm_pkg::GD_BLANK: begin
                    if (!on_cmd) begin
                        state_q <= xbm_pkg::GD_IDLE;
                    end else if (cnt_q <= CNT_W'(1)) begin
                        state_q <= xbm_pkg::GD_WATCH;
                        cnt_q   <= '0;
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
                xbm_pkg::GD_WATCH: begin
                    if (!on_cmd) begin
                        state_q <= xbm_pkg::GD_IDLE;
                    end else if (!over || !mon_en) begin
                        cnt_q <= '0;
                    end else if (cnt_q == CNT_W'(xbm_pkg::FILTER_CYC)) begin
                        state_q <= xbm_pkg::GD_TRIP;
                        trip    <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                xbm_pkg::GD_TRIP: begin
                    if (!on_cmd) begin
                        state_q <= xbm_pkg::GD_IDLE;
                    end
                end
                default: state_q <= xbm_pkg::GD_IDLE;
            endcase
        end
    end

    property p_blank_quiet;
        @(posedge clk) disable iff (!nrst)
        (state_q == xbm_pkg::GD_BLANK) |=> !trip;
    endproperty
    a_blank_quiet: assert property (p_blank_quiet) else $error("trip during blanking");

    property p_trip_held;
        @(posedge clk) disable iff (!nrst)
        $rose(trip) |-> $past(over) && $past(mon_en) && $past(state_q) == xbm_pkg::GD_WATCH;
    endproperty
    a_trip_held: assert property (p_trip_held) else $error("trip without held overvoltage");
endmodule

/* tb/tb_top.sv */
// bench for the vds monitor register block
// assumes host model drives the serial pins
`timescale 1ns/10ps
module tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        chip_select_n, sck, mosi, miso_o, miso_oe_n, standby, sink, src;
    logic [5:0]  sel = 6'h2a;
    logic [5:0]  cur, duty;
    logic [23:0] lvl = 24'h12_3456;
    logic [23:0] lvl_q, r;
    logic [1:0]  on = 2'h0, over = 2'h0, clr = 2'h0, drv, flt;
    logic [7:0]  thr;
    int          n_mismatch = 0, n_tests = 0;
    always #12.5 clk = ~clk;
    xbm_host xbm_host_inst (.clk(clk), .chip_select_n(chip_select_n), .sck(sck), .mosi(mosi),
        .miso_o(miso_o), .miso_oe_n(miso_oe_n));
    xbm_top xbm_top_inst (.clk(clk), .nrst(nrst), .chip_select_n(chip_select_n), .sck(sck), .mosi(mosi),
        .miso_o(miso_o), .miso_oe_n(miso_oe_n), .regulation_type_select(sel), .output_level_code(lvl),
        .current_reg_en(cur), .duty_reg_en(duty), .level_code(lvl_q), .xbridge_on_cmd(on), .vds_over(over),
        .fault_clear(clr), .xbridge_drive(drv), .xbridge_fault(flt), .xbridge_vds_threshold(thr),
        .xbridge2_diag_sink_en(sink), .xbridge2_diag_source_en(src), .standby(standby));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic bad);
        xbm_host_inst.frame(2'h0, a, d, bad, r);
    endtask
    task automatic wrap_up;
        $display("mismatches %0d in %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        xbm_host_inst.frame(2'h1, 6'h06, 16'h0000, 1'b0, r);
        chk(r[14:0], 16'h0176 >> 1);
        chk(thr, 8'hbb);
        chk({cur, duty, lvl_q[11:0]}, {6'h15, 6'h2a, lvl[11:0]});
        chk(lvl_q, lvl);
        wr(6'h06, 16'h5810, 1'b0);
        chk(thr, 8'h08);
        chk({sink, src}, 2'h1);
        wr(6'h08, 16'hffff, 1'b0);
        chk(thr, 8'h08);
        xbm_host_inst.frame(2'h1, 6'h06, 16'h0000, 1'b0, r);
        chk(r[14:0], 16'h5810 >> 1);
        wr(6'h06, 16'h0000, 1'b1);
        chk(thr, 8'h08);
        wr(6'h06, 16'hc010, 1'b0);
        chk({sink, src}, 2'h0);
        on = 2'h1;
        over = 2'h1;
        repeat (78) @(negedge clk);
        chk(flt, 2'h0);
        chk(drv, 2'h1);
        repeat (12) @(negedge clk);
        chk(flt, 2'h1);
        chk(drv, 2'h0);
        on = 2'h0;
        over = 2'h0;
        clr = 2'h1;
        @(negedge clk);
        clr = 2'h0;
        chk(flt, 2'h0);
        wr(6'h06, 16'h0610, 1'b0);
        on = 2'h3;
        over = 2'h3;
        repeat (198) @(negedge clk);
        chk(flt, 2'h0);
        repeat (12) @(negedge clk);
        chk({flt, drv}, 4'h6);
        on = 2'h0;
        over = 2'h0;
        clr = 2'h3;
        @(negedge clk);
        clr = 2'h0;
        wr(6'h07, 16'h2000, 1'b0);
        wr(6'h06, 16'h2010, 1'b0);
        chk(standby, 1'b0);
        wr(6'h07, 16'h0000, 1'b0);
        wr(6'h07, 16'h2000, 1'b0);
        chk({standby, miso_oe_n}, 2'h3);
        xbm_host_inst.frame(2'h1, 6'h06, 16'h0000, 1'b0, r);
        chk(standby, 1'b0);
        wrap_up();
    end
endmodule

/* tb/xbm_host.sv */
// host serial master model: 24-bit frames, sck near 4 MHz
// assumes the bench's 40 MHz clk
`timescale 1ns/10ps
module xbm_host (
    input  wire logic clk,           // system clock
    output logic      chip_select_n, // frame select
    output logic      sck,           // serial clock, idle low
    output logic      mosi,          // serial data out
    input  wire logic miso_o,        // serial data in
    input  wire logic miso_oe_n      // low while device drives
);
    initial begin
        chip_select_n = 1'b1;
        sck           = 1'b0;
        mosi          = 1'b0;
    end
    // one frame msb first; bad flips parity; r collects miso
    task automatic frame(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
                         input logic bad, output logic [23:0] r);
        logic [23:0] f;
        f = {op, a, d[15:1], 1'b0};
        f[0] = ~(^f[23:1]) ^ bad;
        @(negedge clk);
        chip_select_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 23; i >= 0; i--) begin
            mosi = f[i];
            repeat (5) @(negedge clk);
            sck = 1'b1;
            r = {r[22:0], miso_oe_n ? ~miso_o : miso_o}; // released line reads inverted
            repeat (5) @(negedge clk);
            sck = 1'b0;
        end
        repeat (2) @(negedge clk);
        chip_select_n = 1'b1;
        mosi = ~mosi;
        repeat (8) @(negedge clk);
    endtask
endmodule
